// ==== include/gpio_regs.svh ====
// Register offsets, field positions and reset values of the port block
`ifndef GPIO_REGS_SVH
`define GPIO_REGS_SVH
`define ADR_P1_LATCH 6'h00
`define ADR_P1_DIR 6'h01
`define ADR_P1_PULL 6'h02
`define ADR_P1_FSEL 6'h03
`define ADR_P2_LATCH 6'h04
`define ADR_P2_DIR 6'h05
`define ADR_P2_SEG 6'h06
`define ADR_ADPC 6'h07
`define ADR_ISC 6'h08
`define ADR_SAR_SEL 6'h09
`define ADR_DS_CTL 6'h0A
`define ADR_P10_LATCH 6'h0B
`define ADR_P10_DIR 6'h0C
`define ADR_P10_PULL 6'h0D
`define ADR_P14_LATCH 6'h0E
`define ADR_P14_DIR 6'h0F
`define ADR_P14_PULL 6'h10
`define ADR_P15_LATCH 6'h11
`define ADR_P15_DIR 6'h12
`define ADR_P15_PULL 6'h13
`define ADR_P12_LATCH 6'h14
`define ADR_P12_DIR 6'h15
`define ADR_P12_PULL 6'h16
`define ADR_ALL_PORT_FUNCTION_SELECT 6'h17
`define ADR_P12_IN 6'h18
`define DIR4_RST 4'hF
`define DIR8_RST 8'hFF
`define ZERO4 4'h0
`define ZERO8 8'h00
`define ADPC_ALL_ANALOG 4'h0
`define ADPC_MAX 4'h8
`define SAR_CH_MSB 2
`define DS_EN_BIT 2
`define DS_PAIR_MSB 1
`define ISC_RX_BIT 0
`define ISC_TX_BIT 1
`define PF1_TX_BIT 3
`define ALL_PORT_FUNCTION_SELECT_P10 0
`define ALL_PORT_FUNCTION_SELECT_P14 1
`define ALL_PORT_FUNCTION_SELECT_P15 2
`define P1_SO_BIT 3
`define P1_SI_BIT 2
`endif

// ==== include/gpio_pkg.sv ====
// Types shared by the port block
package gpio_pkg;
    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_t;
endpackage : gpio_pkg

// ==== hw/gpio_bitcell.sv ====
// One four-bit port slice: latch, direction, pull-up, pin readback
`timescale 1ns/1ps
`include "gpio_regs.svh"
module gpio_bitcell (
    // Clock and reset
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Register writes
    input wire logic wr_latch_i,
    input wire logic wr_dir_i,
    input wire logic wr_pull_i,
    input wire logic [3:0] wdata_i,
    // Pins
    input wire logic [3:0] pin_i,
    output logic [3:0] pin_o,
    output logic [3:0] pin_oe_b_o,
    output logic [3:0] pull_o,
    output logic [3:0] rdata_o,
    output logic [3:0] dir_o,
    output logic [3:0] pullreg_o
);
    logic [3:0] latch_q;
    logic [3:0] dir_q;
    logic [3:0] pull_q;

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            latch_q <= `ZERO4;
        end else if (ce_i && wr_latch_i) begin
            latch_q <= wdata_i;
        end
    end

    // Direction 1 means input
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dir_q <= `DIR4_RST;
        end else if (ce_i && wr_dir_i) begin
            dir_q <= wdata_i;
        end
    end

    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pull_q <= `ZERO4;
        end else if (ce_i && wr_pull_i) begin
            pull_q <= wdata_i;
        end
    end

    // Registered pin outputs keep glitches off the pads
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            pin_o <= `ZERO4;
            pin_oe_b_o <= `DIR4_RST;
            pull_o <= `ZERO4;
        end else if (ce_i) begin
            pin_o <= latch_q;
            pin_oe_b_o <= dir_q;
            pull_o <= pull_q & dir_q;
        end
    end

    assign rdata_o = (dir_q & pin_i) | (~dir_q & latch_q);
    assign dir_o = dir_q;
    assign pullreg_o = pull_q;

    property p_pull_input;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (pull_o & ~pin_oe_b_o) == `ZERO4;
    endproperty
    a_pull_input: assert property (p_pull_input) else $error("pull-up on driven pin");

    property p_oe_follows;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        ce_i |=> (pin_oe_b_o == $past(dir_q));
    endproperty
    a_oe_follows: assert property (p_oe_follows) else $error("drive enable stale");
endmodule : gpio_bitcell

// ==== hw/gpio_ports.sv ====
// Port 1, 2, 10, 12, 14 and 15 logic with a Wishbone register slave
// Function
// - Port 1 four bits, per-bit latch and direction
// - Port 1 pull-up only when bit is input
// - Reset puts port 1 in input mode
// - Port 2 eight bits, no pull-up
// - Analog input unconverted; conflicting settings prohibited (code accepts them and raises p2_conflict_o)
// - Analog pins routed to selected converter
// - Input switch moves secondary serial to port 1
// - Ports 10, 14, 15 four bits with pull-ups
// - Port 12 one I/O bit, four inputs
//
// Added by the designer: the address map and the Wishbone register port.
`timescale 1ns/1ps
`include "gpio_regs.svh"
module gpio_ports
    import gpio_pkg::*;
(
    // Clock, reset, enable
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic ce_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [5:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Port 1
    input wire logic [3:0] p1_pin_i,
    output logic [3:0] p1_pin_o,
    output logic [3:0] p1_oe_b_o,
    output logic [3:0] p1_pull_o,
    // Secondary serial
    input wire logic uart2_txd_i,
    output logic uart2_rxd_o,
    input wire logic serial_so_i,
    input wire logic serial_active_i,
    // Port 2
    input wire logic [7:0] p2_pin_i,
    output logic [7:0] p2_pin_o,
    output logic [7:0] p2_oe_b_o,
    output logic [7:0] p2_analog_o,
    output logic [7:0] segment_output_en_o,
    output logic [7:0] sar_analog_input_o,
    output logic [7:0] delta_sigma_input_pair_o,
    output logic p2_conflict_o,
    // Ports 10, 14, 15
    input wire logic [11:0] pseg_pin_i,
    output logic [11:0] pseg_pin_o,
    output logic [11:0] pseg_oe_b_o,
    output logic [11:0] pseg_pull_o,
    output logic [2:0] pseg_segment_en_o,
    // Port 12: bit 0 I/O, bits 4..1 input only
    input wire logic [4:0] p12_pin_i,
    output logic p12_pin_o,
    output logic p12_oe_b_o,
    output logic p12_pull_o
);
    logic [3:0] port_one_latch_q;
    logic [3:0] port_one_direction_q;
    logic [3:0] port_one_pullup_enable_q;
    logic [3:0] port_one_function_select_q;
    logic [7:0] port_two_latch_q;
    logic [7:0] port_two_direction_q;
    logic [7:0] port_two_segment_select_q;
    logic [3:0] analog_digital_pin_config_q;
    logic [1:0] input_switch_control_q;
    logic [2:0] sar_channel_select_q;
    logic [2:0] delta_sigma_control_q;
    logic [2:0] all_port_function_select_q;
    logic p12_latch_q;
    logic p12_dir_q;
    logic p12_pull_q;
    bus_state_t bus_q;
    logic [31:0] rdata_d;
    logic acc;
    logic wr;
    logic [7:0] digital_mask;
    logic [7:0] sar_sel;
    logic [7:0] ds_sel;
    logic [3:0] seg_rd [3];
    logic [3:0] seg_dir [3];
    logic [3:0] seg_pull [3];

    function automatic logic wr_at(input logic [5:0] a);
        wr_at = wr && (wb_adr_i == a);
    endfunction : wr_at

    function automatic logic [7:0] readback8(input logic [7:0] d, input logic [7:0] p,
                                             input logic [7:0] l);
        readback8 = (d & p) | (~d & l);
    endfunction : readback8

    assign acc = wb_cyc_i && wb_stb_i && (bus_q == BUS_IDLE);
    assign wr = ce_i && acc && wb_we_i && wb_sel_i[0];

    // Single-wait slave: ack one cycle after strobe, then dropped
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            bus_q <= BUS_IDLE;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            case (bus_q)
                BUS_IDLE: begin
                    wb_ack_o <= acc;
                    wb_dat_o <= rdata_d;
                    if (acc) begin
                        bus_q <= BUS_ACK;
                    end
                end
                BUS_ACK: begin
                    wb_ack_o <= 1'b0;
                    bus_q <= BUS_IDLE;
                end
                default: begin
                    wb_ack_o <= 1'b0;
                    bus_q <= BUS_IDLE;
                end
            endcase
        end
    end

    // Port 1 and port 2 control registers
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            port_one_latch_q <= `ZERO4;
            port_one_direction_q <= `DIR4_RST;
            port_one_pullup_enable_q <= `ZERO4;
            port_one_function_select_q <= `ZERO4;
            port_two_latch_q <= `ZERO8;
            port_two_direction_q <= `DIR8_RST;
            port_two_segment_select_q <= `ZERO8;
            analog_digital_pin_config_q <= `ADPC_ALL_ANALOG;
        end else begin
            if (wr_at(`ADR_P1_LATCH)) port_one_latch_q <= wb_dat_i[3:0];
            if (wr_at(`ADR_P1_DIR)) port_one_direction_q <= wb_dat_i[3:0];
            if (wr_at(`ADR_P1_PULL)) port_one_pullup_enable_q <= wb_dat_i[3:0];
            if (wr_at(`ADR_P1_FSEL)) port_one_function_select_q <= wb_dat_i[3:0];
            if (wr_at(`ADR_P2_LATCH)) port_two_latch_q <= wb_dat_i[7:0];
            if (wr_at(`ADR_P2_DIR)) port_two_direction_q <= wb_dat_i[7:0];
            if (wr_at(`ADR_P2_SEG)) port_two_segment_select_q <= wb_dat_i[7:0];
            // Count of low pins made digital, clamped so bits stay contiguous
            if (wr_at(`ADR_ADPC)) begin
                analog_digital_pin_config_q <= (wb_dat_i[3:0] > `ADPC_MAX) ?
                    `ADPC_MAX : wb_dat_i[3:0];
            end
        end
    end

    // Converter selects, input switch, segment and port 12 settings
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            input_switch_control_q <= 2'h0;
            sar_channel_select_q <= 3'h0;
            delta_sigma_control_q <= 3'h0;
            all_port_function_select_q <= 3'h0;
            p12_latch_q <= 1'b0;
            p12_dir_q <= 1'b1;
            p12_pull_q <= 1'b0;
        end else begin
            if (wr_at(`ADR_ISC)) input_switch_control_q <= wb_dat_i[1:0];
            if (wr_at(`ADR_SAR_SEL)) sar_channel_select_q <= wb_dat_i[2:0];
            if (wr_at(`ADR_DS_CTL)) delta_sigma_control_q <= wb_dat_i[2:0];
            if (wr_at(`ADR_ALL_PORT_FUNCTION_SELECT)) all_port_function_select_q <= wb_dat_i[2:0];
            if (wr_at(`ADR_P12_LATCH)) p12_latch_q <= wb_dat_i[0];
            if (wr_at(`ADR_P12_DIR)) p12_dir_q <= wb_dat_i[0];
            if (wr_at(`ADR_P12_PULL)) p12_pull_q <= wb_dat_i[0];
        end
    end

    // Analog routing of port 2
    always_comb begin
        digital_mask = ~(8'hFF << analog_digital_pin_config_q);
        sar_sel = 8'h01 << sar_channel_select_q;
        ds_sel = delta_sigma_control_q[`DS_EN_BIT] ?
            (8'h03 << {delta_sigma_control_q[`DS_PAIR_MSB:0], 1'b0}) : 8'h00;
    end

    // Port 1 pins; P13 may carry the secondary transmitter
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            p1_pin_o <= `ZERO4;
            p1_oe_b_o <= `DIR4_RST;
            p1_pull_o <= `ZERO4;
            uart2_rxd_o <= 1'b1;
        end else if (ce_i) begin
            p1_pin_o <= port_one_latch_q;
            if (input_switch_control_q[`ISC_TX_BIT] &&
                port_one_function_select_q[`PF1_TX_BIT]) begin
                p1_pin_o[`P1_SO_BIT] <= uart2_txd_i & port_one_latch_q[`P1_SO_BIT];
            end else if (serial_active_i) begin
                p1_pin_o[`P1_SO_BIT] <= serial_so_i & port_one_latch_q[`P1_SO_BIT];
            end
            p1_oe_b_o <= port_one_direction_q;
            p1_pull_o <= port_one_pullup_enable_q & port_one_direction_q;
            uart2_rxd_o <= input_switch_control_q[`ISC_RX_BIT] ?
                p1_pin_i[`P1_SI_BIT] : 1'b1;
        end
    end

    // Port 2 pins and converter routing
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            p2_pin_o <= `ZERO8;
            p2_oe_b_o <= `DIR8_RST;
            p2_analog_o <= `DIR8_RST;
            segment_output_en_o <= `ZERO8;
            sar_analog_input_o <= `ZERO8;
            delta_sigma_input_pair_o <= `ZERO8;
            p2_conflict_o <= 1'b0;
        end else if (ce_i) begin
            p2_pin_o <= port_two_latch_q;
            // Pad driven only for digital output, never for analog or segment
            p2_oe_b_o <= ~(~port_two_segment_select_q & digital_mask
                           & ~port_two_direction_q);
            p2_analog_o <= ~port_two_segment_select_q & ~digital_mask;
            segment_output_en_o <= port_two_segment_select_q;
            sar_analog_input_o <= sar_sel & ~digital_mask & port_two_direction_q
                                  & ~port_two_segment_select_q & ~ds_sel;
            delta_sigma_input_pair_o <= ds_sel & ~digital_mask & port_two_direction_q
                                        & ~port_two_segment_select_q & ~sar_sel;
            p2_conflict_o <= |(~port_two_segment_select_q & ~digital_mask
                               & (~port_two_direction_q | (sar_sel & ds_sel)));
        end
    end

    // Port 12 output bit and segment enables of ports 10, 14, 15
    always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            p12_pin_o <= 1'b0;
            p12_oe_b_o <= 1'b1;
            p12_pull_o <= 1'b0;
            pseg_segment_en_o <= 3'h0;
        end else if (ce_i) begin
            p12_pin_o <= p12_latch_q;
            p12_oe_b_o <= p12_dir_q;
            p12_pull_o <= p12_pull_q & p12_dir_q;
            pseg_segment_en_o <= all_port_function_select_q;
        end
    end

    // Ports 10, 14, 15 share one slice design
    for (genvar g = 0; g < 3; g++) begin : g_seg
        gpio_bitcell u_cell (
            .ref_clk_i(ref_clk_i),
            .rst_b_i(rst_b_i),
            .ce_i(ce_i),
            .wr_latch_i(wr_at(6'(`ADR_P10_LATCH + 3 * g))),
            .wr_dir_i(wr_at(6'(`ADR_P10_DIR + 3 * g))),
            .wr_pull_i(wr_at(6'(`ADR_P10_PULL + 3 * g))),
            .wdata_i(wb_dat_i[3:0]),
            .pin_i(pseg_pin_i[4*g +: 4]),
            .pin_o(pseg_pin_o[4*g +: 4]),
            .pin_oe_b_o(pseg_oe_b_o[4*g +: 4]),
            .pull_o(pseg_pull_o[4*g +: 4]),
            .rdata_o(seg_rd[g]),
            .dir_o(seg_dir[g]),
            .pullreg_o(seg_pull[g])
        );
    end

    // Read mux
    always_comb begin
        rdata_d = 32'h0000_0000;
        case (wb_adr_i)
            `ADR_P1_LATCH: rdata_d[7:0] = readback8({4'h0, port_one_direction_q},
                {4'h0, p1_pin_i}, {4'h0, port_one_latch_q});
            `ADR_P1_DIR: rdata_d[3:0] = port_one_direction_q;
            `ADR_P1_PULL: rdata_d[3:0] = port_one_pullup_enable_q;
            `ADR_P1_FSEL: rdata_d[3:0] = port_one_function_select_q;
            `ADR_P2_LATCH: rdata_d[7:0] = readback8(port_two_direction_q,
                p2_pin_i & digital_mask, port_two_latch_q);
            `ADR_P2_DIR: rdata_d[7:0] = port_two_direction_q;
            `ADR_P2_SEG: rdata_d[7:0] = port_two_segment_select_q;
            `ADR_ADPC: rdata_d[3:0] = analog_digital_pin_config_q;
            `ADR_ISC: rdata_d[1:0] = input_switch_control_q;
            `ADR_SAR_SEL: rdata_d[2:0] = sar_channel_select_q;
            `ADR_DS_CTL: rdata_d[2:0] = delta_sigma_control_q;
            `ADR_P10_LATCH: rdata_d[3:0] = seg_rd[0];
            `ADR_P10_DIR: rdata_d[3:0] = seg_dir[0];
            `ADR_P10_PULL: rdata_d[3:0] = seg_pull[0];
            `ADR_P14_LATCH: rdata_d[3:0] = seg_rd[1];
            `ADR_P14_DIR: rdata_d[3:0] = seg_dir[1];
            `ADR_P14_PULL: rdata_d[3:0] = seg_pull[1];
            `ADR_P15_LATCH: rdata_d[3:0] = seg_rd[2];
            `ADR_P15_DIR: rdata_d[3:0] = seg_dir[2];
            `ADR_P15_PULL: rdata_d[3:0] = seg_pull[2];
            `ADR_P12_LATCH: rdata_d[0] = p12_dir_q ? p12_pin_i[0] : p12_latch_q;
            `ADR_P12_DIR: rdata_d[0] = p12_dir_q;
            `ADR_P12_PULL: rdata_d[0] = p12_pull_q;
            `ADR_ALL_PORT_FUNCTION_SELECT: rdata_d[2:0] = all_port_function_select_q;
            `ADR_P12_IN: rdata_d[4:0] = p12_pin_i;
            default: rdata_d = 32'h0000_0000;
        endcase
    end

    sequence s_ack_pulse;
        wb_ack_o ##1 (!wb_ack_o || !ce_i);
    endsequence

    property p_ack_one;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (ce_i && acc) |=> s_ack_pulse;
    endproperty
    a_ack_one: assert property (p_ack_one) else $error("ack not one cycle");

    property p_p1_pull;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (p1_pull_o & ~p1_oe_b_o) == 4'h0;
    endproperty
    a_p1_pull: assert property (p_p1_pull) else $error("pull-up on output");

    property p_p2_analog_float;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (p2_analog_o & ~p2_oe_b_o) == 8'h00;
    endproperty
    a_p2_analog_float: assert property (p_p2_analog_float) else $error("analog driven");

    property p_conv_excl;
        @(posedge ref_clk_i) disable iff (!rst_b_i)
        (sar_analog_input_o & delta_sigma_input_pair_o) == 8'h00;
    endproperty
    a_conv_excl: assert property (p_conv_excl) else $error("both converters");
endmodule : gpio_ports

// ==== tb/gpio_pin_model.sv ====
// Pad model for the port pins: driven, pulled up or floating
`timescale 1ns/1ps
module gpio_pin_model #(
    parameter int W = 4
) (
    // Clock
    input wire logic ref_clk_i,
    // Device side
    input wire logic [W-1:0] out_i,
    input wire logic [W-1:0] oe_b_i,
    input wire logic [W-1:0] pull_i,
    // Outside world
    input wire logic [W-1:0] ext_en_i,
    input wire logic [W-1:0] ext_i,
    output logic [W-1:0] pad_o
);
    logic [W-1:0] float_q = '0;

    // Undriven pads wander, so a stale level never passes for a real one
    always_ff @(posedge ref_clk_i) begin
        float_q <= ~float_q;
    end

    always_comb begin
        for (int i = 0; i < W; i++) begin
            pad_o[i] = !oe_b_i[i] ? out_i[i] : ext_en_i[i] ? ext_i[i] :
                       pull_i[i] ? 1'b1 : float_q[i];
        end
    end
endmodule : gpio_pin_model

// ==== tb/mcu_gpio_ports_1_2_and_pin_select_tb.sv ====
// Self-checking bench for the port block
`timescale 1ns/1ps
`include "gpio_regs.svh"
module mcu_gpio_ports_1_2_and_pin_select_tb;
    logic ref_clk_i, rst_b_i, ce_i, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [5:0] wb_adr_i;
    logic [3:0] wb_sel_i, p1_pin_i, p1_pin_o, p1_oe_b_o, p1_pull_o, p1_ext, p1_ext_en;
    logic [31:0] wb_dat_i, wb_dat_o, rd, a, b, c;
    logic uart2_txd_i, uart2_rxd_o, serial_so_i, serial_active_i, p2_conflict_o;
    logic [7:0] p2_pin_i, p2_pin_o, p2_oe_b_o, p2_analog_o, p2_ext, p2_ext_en;
    logic [7:0] segment_output_en_o, sar_analog_input_o, delta_sigma_input_pair_o;
    logic [11:0] pseg_pin_i, pseg_pin_o, pseg_oe_b_o, pseg_pull_o, pseg_ext, pseg_ext_en;
    logic [2:0] pseg_segment_en_o;
    logic [4:0] p12_pin_i, p12_ext, p12_ext_en;
    logic p12_pin_o, p12_oe_b_o, p12_pull_o;
    int bad_count = 0;
    int num_checks = 0;
    int cycles = 0;
    int seed;

    gpio_ports i_dut (.ref_clk_i, .rst_b_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_we_i,
        .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .p1_pin_i, .p1_pin_o,
        .p1_oe_b_o, .p1_pull_o, .uart2_txd_i, .uart2_rxd_o, .serial_so_i,
        .serial_active_i, .p2_pin_i, .p2_pin_o, .p2_oe_b_o, .p2_analog_o,
        .segment_output_en_o, .sar_analog_input_o, .delta_sigma_input_pair_o,
        .p2_conflict_o, .pseg_pin_i, .pseg_pin_o, .pseg_oe_b_o, .pseg_pull_o,
        .pseg_segment_en_o, .p12_pin_i, .p12_pin_o, .p12_oe_b_o, .p12_pull_o);
    gpio_pin_model #(.W(4)) i_p1 (.ref_clk_i, .out_i(p1_pin_o), .oe_b_i(p1_oe_b_o),
        .pull_i(p1_pull_o), .ext_en_i(p1_ext_en), .ext_i(p1_ext), .pad_o(p1_pin_i));
    gpio_pin_model #(.W(8)) i_p2 (.ref_clk_i, .out_i(p2_pin_o), .oe_b_i(p2_oe_b_o),
        .pull_i(8'h00), .ext_en_i(p2_ext_en), .ext_i(p2_ext), .pad_o(p2_pin_i));
    gpio_pin_model #(.W(12)) i_ps (.ref_clk_i, .out_i(pseg_pin_o), .oe_b_i(pseg_oe_b_o),
        .pull_i(pseg_pull_o), .ext_en_i(pseg_ext_en), .ext_i(pseg_ext), .pad_o(pseg_pin_i));
    gpio_pin_model #(.W(5)) i_p12 (.ref_clk_i, .out_i({4'h0, p12_pin_o}),
        .oe_b_i({4'hF, p12_oe_b_o}), .pull_i({4'h0, p12_pull_o}), .ext_en_i(p12_ext_en),
        .ext_i(p12_ext), .pad_o(p12_pin_i));

    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    // Hang guard, well above the six hundred or so cycles the run needs
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            bad_count++;
            report_and_stop();
        end
    end

    task report_and_stop;
        if (bad_count == 0 && num_checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : report_and_stop

    task chk(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            bad_count++;
            $display("[ERR] %0t exp %h got %h", $time, e, g);
        end
    endtask : chk

    // Classic single cycle; waits on ack and checks it arrives on the second clock
    task wb(input logic we, input logic [3:0] sel, input logic [5:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge ref_clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_adr_i <= ad;
        wb_dat_i <= d;
        do begin
            @(posedge ref_clk_i);
            n++;
        end while (wb_ack_o !== 1'b1);
        chk(2, n);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask : wb

    task wr(input logic [5:0] ad, input logic [31:0] d);
        wb(1'b1, 4'hF, ad, d);
    endtask : wr

    task rdc(input logic [5:0] ad, input logic [31:0] e);
        wb(1'b0, 4'hF, ad, 32'h0);
        chk(e, rd);
    endtask : rdc

    // Pin outputs trail the register write by a clock
    task settle;
        repeat (3) @(posedge ref_clk_i);
    endtask : settle

    function automatic logic [7:0] mix(input logic [7:0] dir, pin, lat);
        return (dir & pin) | (~dir & lat);
    endfunction : mix

    function automatic logic [7:0] dmask(input int k);
        return 8'((16'h1 << k) - 1);
    endfunction : dmask

    initial begin
        logic [7:0] m, dir, lat;
        int n;
        seed = 1004;
        {rst_b_i, wb_cyc_i, wb_stb_i, wb_we_i, uart2_txd_i, serial_so_i} = '0;
        ce_i = 1'b1;
        serial_active_i = 1'b0;
        {wb_adr_i, wb_dat_i, wb_sel_i, p1_ext, p2_ext, pseg_ext, p12_ext} = '0;
        p1_ext_en = 4'hF;
        {p2_ext_en, pseg_ext_en, p12_ext_en} = {8'hFF, 12'hFFF, 5'h1E};
        repeat (3) @(posedge ref_clk_i);
        chk(24'hF0FFFF, {p1_oe_b_o, p1_pull_o, p2_oe_b_o, p2_analog_o});
        chk(27'h7FF8004, {pseg_oe_b_o, pseg_pull_o, p12_oe_b_o, p12_pull_o, wb_ack_o});
        rst_b_i <= 1'b1;
        rdc(`ADR_P1_DIR, `DIR4_RST);
        rdc(`ADR_P2_DIR, `DIR8_RST);
        rdc(`ADR_ADPC, `ADPC_ALL_ANALOG);
        rdc(`ADR_P1_PULL, 0);
        rdc(6'h3F, 0);
        repeat (8) begin
            a = $random(seed);
            b = $random(seed);
            c = $random(seed);
            @(posedge ref_clk_i);
            p1_ext <= a[15:12];
            serial_so_i <= a[16];
            wr(`ADR_P1_DIR, a[3:0]);
            wr(`ADR_P1_LATCH, b[3:0]);
            wr(`ADR_P1_PULL, c[3:0]);
            settle();
            chk(a[3:0], p1_oe_b_o);
            chk(4'(b[3:0] & ~a[3:0]), 4'(p1_pin_o & ~a[3:0]));
            chk(4'(c[3:0] & a[3:0]), p1_pull_o);
            rdc(`ADR_P1_LATCH, mix(a[3:0], a[15:12], b[3:0]));
        end
        wr(`ADR_P1_DIR, 4'hF);
        wr(`ADR_P1_PULL, 4'hF);
        @(posedge ref_clk_i);
        p1_ext_en <= 4'h0;
        settle();
        rdc(`ADR_P1_LATCH, 4'hF);
        p1_ext_en <= 4'hF;
        wr(`ADR_P2_SEG, 0);
        for (int k = 0; k <= 9; k++) begin
            a = $random(seed);
            m = dmask(k > 8 ? 8 : k);
            dir = a[7:0] | ~m;
            lat = a[23:16];
            @(posedge ref_clk_i);
            p2_ext <= a[15:8];
            wr(`ADR_ADPC, k);
            wr(`ADR_P2_DIR, dir);
            wr(`ADR_P2_LATCH, lat);
            settle();
            chk(8'(~m), p2_analog_o);
            chk(8'(~(m & ~dir)), p2_oe_b_o);
            chk(8'(lat & ~dir), 8'(p2_pin_o & ~dir));
            rdc(`ADR_P2_LATCH, 8'(mix(dir, a[15:8], lat) & m));
        end
        a = $random(seed);
        wr(`ADR_P2_SEG, a[7:0]);
        settle();
        chk(a[7:0], segment_output_en_o);
        chk(8'(~(~dir & ~a[7:0])), p2_oe_b_o);
        wr(`ADR_P2_SEG, 0);
        wr(`ADR_ADPC, 0);
        wr(`ADR_P2_DIR, 8'hFF);
        for (int ch = 0; ch < 8; ch++) begin
            n = (ch / 2 + 1) % 3;
            wr(`ADR_SAR_SEL, ch);
            wr(`ADR_DS_CTL, 0);
            settle();
            chk({8'h0, 8'(1 << ch), 1'b0}, {delta_sigma_input_pair_o, sar_analog_input_o,
                p2_conflict_o});
            wr(`ADR_DS_CTL, 4 | n);
            settle();
            chk({8'(3 << 2 * n), 8'(1 << ch), 1'b0}, {delta_sigma_input_pair_o,
                sar_analog_input_o, p2_conflict_o});
        end
        wr(`ADR_SAR_SEL, 2);
        wr(`ADR_DS_CTL, 4 | 1);
        settle();
        chk(3'b100, {p2_conflict_o, sar_analog_input_o[2], delta_sigma_input_pair_o[2]});
        wr(`ADR_DS_CTL, 0);
        wr(`ADR_P2_DIR, 8'hFB);
        settle();
        chk(1, p2_conflict_o);
        wr(`ADR_P2_DIR, 8'hFF);
        settle();
        chk(0, p2_conflict_o);
        wr(`ADR_P1_DIR, 4'h7);
        wr(`ADR_P1_LATCH, 4'h8);
        wr(`ADR_P1_FSEL, 4'h8);
        wr(`ADR_ISC, 3);
        repeat (4) begin
            a = $random(seed);
            @(posedge ref_clk_i);
            p1_ext <= a[3:0];
            uart2_txd_i <= a[4];
            settle();
            chk({a[2], a[4]}, {uart2_rxd_o, p1_pin_o[3]});
        end
        uart2_txd_i <= 1'b0;
        wr(`ADR_ISC, 0);
        settle();
        chk(2'b11, {uart2_rxd_o, p1_pin_o[3]});
        serial_active_i <= 1'b1;
        serial_so_i <= 1'b0;
        ce_i <= 1'b0;
        settle();
        chk(1, p1_pin_o[3]);
        ce_i <= 1'b1;
        settle();
        chk(0, p1_pin_o[3]);
        serial_active_i <= 1'b0;
        for (int p = 0; p < 3; p++) begin
            a = $random(seed);
            @(posedge ref_clk_i);
            pseg_ext[4 * p +: 4] <= a[15:12];
            wr(6'(`ADR_P10_DIR + 3 * p), a[3:0]);
            wr(6'(`ADR_P10_LATCH + 3 * p), a[7:4]);
            wr(6'(`ADR_P10_PULL + 3 * p), a[11:8]);
            settle();
            chk({a[3:0], 4'(a[11:8] & a[3:0]), 4'(a[7:4] & ~a[3:0])}, {pseg_oe_b_o[4 * p +: 4],
                pseg_pull_o[4 * p +: 4], 4'(pseg_pin_o[4 * p +: 4] & ~a[3:0])});
            rdc(6'(`ADR_P10_LATCH + 3 * p), mix(a[3:0], a[15:12], a[7:4]));
        end
        wr(`ADR_ALL_PORT_FUNCTION_SELECT, 3'h5);
        settle();
        chk(3'h5, pseg_segment_en_o);
        a = $random(seed);
        @(posedge ref_clk_i);
        p12_ext <= a[4:0];
        wr(`ADR_P12_DIR, 0);
        wr(`ADR_P12_LATCH, 1);
        wr(`ADR_P12_PULL, 1);
        settle();
        chk(3'b010, {p12_oe_b_o, p12_pin_o, p12_pull_o});
        rdc(`ADR_P12_IN, {a[4:1], 1'b1});
        wb(1'b1, 4'h0, `ADR_P12_DIR, 1);
        wr(6'h3F, 32'hFFFF_FFFF);
        rdc(`ADR_P12_DIR, 0);
        rdc(6'h3F, 0);
        report_and_stop();
    end
endmodule : mcu_gpio_ports_1_2_and_pin_select_tb
